// ### hw/bssw_top.sv
// Functional notes
// - unused legacy status bits read zero
// - master parity flag set on secondary parity
// - master parity flag needs parity response enable
// - signaled target abort on completer-abort completion sent
// - received target abort on completer-abort completion
// - received master abort on unsupported-request completion
// - received system error on fatal/nonfatal with forwarding
// - detected parity on poisoned TLP received
// - memory base bits 31:20, low zeros
// - memory limit bits 31:20, low ones
// - memory window decides memory forwarding
// - prefetch registers show 64-bit code 0001
// - prefetch base low field plus upper word
// - prefetch limit low field plus upper word
// - prefetch window decides read/write forwarding
// - parity response enable gates poison reporting, not detected parity
// - error forwarding enable passes error messages
// - upper prefetch base and limit words
//
// Implementation choice: the AXI4-Lite register port.
module bssw_top
	import bssw_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ev_sec_parity,
	input  wire logic        ev_cpl_abort_sent,
	input  wire logic        ev_cpl_abort_rcvd,
	input  wire logic        ev_cpl_unsup_rcvd,
	input  wire logic        ev_err_msg_fatal,
	input  wire logic        ev_err_msg_nonfatal,
	input  wire logic        ev_err_msg_corr,
	input  wire logic        ev_poisoned_rcvd,
	input  wire logic [63:0] txn_addr,
	output logic             mem_window_hit,
	output logic             pref_window_hit,
	output logic             poison_report,
	output logic             err_msg_forward,
	output logic             parity_response_en,
	output logic             system_error_forward_en
);
	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        mst_parity;
		logic        sig_tgt_abort;
		logic        rcv_tgt_abort;
		logic        rcv_mst_abort;
		logic        rcv_sys_err;
		logic        det_parity;
		logic [11:0] mem_base;
		logic [11:0] mem_limit;
		logic [11:0] pref_base;
		logic [11:0] pref_limit;
		logic [31:0] pref_base_hi;
		logic [31:0] pref_limit_hi;
		logic        parity_resp_en;
		logic        serr_fwd_en;
		logic        poison_rpt;
		logic        err_fwd;
	} bssw_state_t;

	bssw_state_t st_q;
	bssw_state_t st_d;

	logic [31:0] status_word;
	logic [31:0] mem_word;
	logic [31:0] pref_word;
	logic [31:0] ctrl_word;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        wr_fire;
	logic        wr_ok;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic        clr_stat;
	logic [31:0] mem_base_x;
	logic [31:0] mem_limit_x;
	logic [63:0] pref_base_x;
	logic [63:0] pref_limit_x;

	always_comb begin
		status_word = '0;
		status_word[BIT_MASTER_PARITY] = st_q.mst_parity;
		status_word[BIT_SIG_TGT_ABORT] = st_q.sig_tgt_abort;
		status_word[BIT_RCV_TGT_ABORT] = st_q.rcv_tgt_abort;
		status_word[BIT_RCV_MST_ABORT] = st_q.rcv_mst_abort;
		status_word[BIT_RCV_SYS_ERR]   = st_q.rcv_sys_err;
		status_word[BIT_DET_PARITY]    = st_q.det_parity;
		mem_word = '0;
		mem_word[LO_FIELD_LSB +: FIELD_W] = st_q.mem_base;
		mem_word[HI_FIELD_LSB +: FIELD_W] = st_q.mem_limit;
		pref_word = '0;
		pref_word[ATTR_LSB_LO +: 4] = PREF_64BIT_CODE;
		pref_word[ATTR_LSB_HI +: 4] = PREF_64BIT_CODE;
		pref_word[LO_FIELD_LSB +: FIELD_W] = st_q.pref_base;
		pref_word[HI_FIELD_LSB +: FIELD_W] = st_q.pref_limit;
		ctrl_word = '0;
		ctrl_word[BIT_PARITY_RESP_EN] = st_q.parity_resp_en;
		ctrl_word[BIT_SERR_FWD_EN]    = st_q.serr_fwd_en;
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_word = '0;
		unique case (s_axi_araddr)
			OFF_SEC_STATUS:    rd_word = status_word;
			OFF_MEM_WINDOW:    rd_word = mem_word;
			OFF_PREF_WINDOW:   rd_word = pref_word;
			OFF_PREF_BASE_HI:  rd_word = st_q.pref_base_hi;
			OFF_PREF_LIMIT_HI: rd_word = st_q.pref_limit_hi;
			OFF_BRIDGE_CTRL:   rd_word = ctrl_word;
			default:           rd_ok   = 1'b0;
		endcase
	end

	// write performed once both address and data are held
	assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;
	assign wr_ok   = (st_q.aw_addr == OFF_SEC_STATUS) || (st_q.aw_addr == OFF_MEM_WINDOW)
		|| (st_q.aw_addr == OFF_PREF_WINDOW) || (st_q.aw_addr == OFF_PREF_BASE_HI)
		|| (st_q.aw_addr == OFF_PREF_LIMIT_HI) || (st_q.aw_addr == OFF_BRIDGE_CTRL);
	assign wmask   = {{8{st_q.w_strb[3]}}, {8{st_q.w_strb[2]}},
		{8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
	assign wval    = st_q.w_data & wmask;
	assign clr_stat = wr_fire && (st_q.aw_addr == OFF_SEC_STATUS);

	assign s_axi_awready = !st_q.aw_held;
	assign s_axi_wready  = !st_q.w_held;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;

	always_comb begin
		st_d = st_q;
		if (s_axi_awvalid && !st_q.aw_held) begin
			st_d.aw_held = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_q.w_held) begin
			st_d.w_held = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_d.aw_held = 1'b0;
			st_d.w_held  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
			unique case (st_q.aw_addr)
				OFF_MEM_WINDOW: begin
					if (st_q.w_strb[0] && st_q.w_strb[1])
						st_d.mem_base = wval[LO_FIELD_LSB +: FIELD_W];
					if (st_q.w_strb[2] && st_q.w_strb[3])
						st_d.mem_limit = wval[HI_FIELD_LSB +: FIELD_W];
				end
				OFF_PREF_WINDOW: begin
					if (st_q.w_strb[0] && st_q.w_strb[1])
						st_d.pref_base = wval[LO_FIELD_LSB +: FIELD_W];
					if (st_q.w_strb[2] && st_q.w_strb[3])
						st_d.pref_limit = wval[HI_FIELD_LSB +: FIELD_W];
				end
				OFF_PREF_BASE_HI:
					st_d.pref_base_hi = (st_q.pref_base_hi & ~wmask) | wval;
				OFF_PREF_LIMIT_HI:
					st_d.pref_limit_hi = (st_q.pref_limit_hi & ~wmask) | wval;
				OFF_BRIDGE_CTRL: begin
					if (st_q.w_strb[2]) begin
						st_d.parity_resp_en = wval[BIT_PARITY_RESP_EN];
						st_d.serr_fwd_en    = wval[BIT_SERR_FWD_EN];
					end
				end
				default: ;
			endcase
		end
		if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;
		if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
		if (s_axi_arvalid && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = rd_word;
			st_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		// write-one-to-clear first, so a same-cycle event still sets
		if (clr_stat) begin
			if (wval[BIT_MASTER_PARITY])
				st_d.mst_parity = 1'b0;
			if (wval[BIT_RCV_SYS_ERR])
				st_d.rcv_sys_err = 1'b0;
			if (wval[BIT_DET_PARITY])
				st_d.det_parity = 1'b0;
		end
		if (ev_sec_parity && st_q.parity_resp_en)
			st_d.mst_parity = 1'b1;
		if (ev_cpl_abort_sent)
			st_d.sig_tgt_abort = 1'b1;
		if (ev_cpl_abort_rcvd)
			st_d.rcv_tgt_abort = 1'b1;
		if (ev_cpl_unsup_rcvd)
			st_d.rcv_mst_abort = 1'b1;
		if ((ev_err_msg_fatal || ev_err_msg_nonfatal) && st_q.serr_fwd_en)
			st_d.rcv_sys_err = 1'b1;
		if (ev_poisoned_rcvd)
			st_d.det_parity = 1'b1;
		st_d.poison_rpt = ev_poisoned_rcvd && st_q.parity_resp_en;
		st_d.err_fwd = (ev_err_msg_fatal || ev_err_msg_nonfatal || ev_err_msg_corr)
			&& st_q.serr_fwd_en;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.mem_base      <= WINDOW_RESET;
			st_q.mem_limit     <= WINDOW_RESET;
			st_q.pref_base     <= WINDOW_RESET;
			st_q.pref_limit    <= WINDOW_RESET;
			st_q.pref_base_hi  <= UPPER_RESET;
			st_q.pref_limit_hi <= UPPER_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign mem_base_x   = {st_q.mem_base, LOW_ZERO};
	assign mem_limit_x  = {st_q.mem_limit, LOW_ONES};
	assign pref_base_x  = {st_q.pref_base_hi, st_q.pref_base, LOW_ZERO};
	assign pref_limit_x = {st_q.pref_limit_hi, st_q.pref_limit, LOW_ONES};

	// memory window decode, never hit above 4G
	bssw_window_match #(
		.AW (64)
	) u_mem_match (
		.addr  (txn_addr),
		.base  ({32'h0000_0000, mem_base_x}),
		.limit ({32'h0000_0000, mem_limit_x}),
		.hit   (mem_window_hit)
	);

	bssw_window_match #(
		.AW (64)
	) u_pref_match (
		.addr  (txn_addr),
		.base  (pref_base_x),
		.limit (pref_limit_x),
		.hit   (pref_window_hit)
	);

	assign poison_report           = st_q.poison_rpt;
	assign err_msg_forward         = st_q.err_fwd;
	assign parity_response_en      = st_q.parity_resp_en;
	assign system_error_forward_en = st_q.serr_fwd_en;

	a_parity_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(!st_q.mst_parity && !parity_response_en) |=> !st_q.mst_parity)
		else $error("master parity set while response disabled");
	a_parity_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(ev_sec_parity && parity_response_en) |=> st_q.mst_parity)
		else $error("master parity not set");
	a_poison_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_poisoned_rcvd |=> status_word[BIT_DET_PARITY])
		else $error("detected parity not set");
	a_sys_err_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_q.rcv_sys_err) |-> $past(st_q.serr_fwd_en))
		else $error("system error set while forwarding disabled");
	a_sig_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		(ev_cpl_abort_sent || st_q.sig_tgt_abort) |=> st_q.sig_tgt_abort)
		else $error("signaled target abort not set or cleared");
	a_rcv_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_cpl_abort_rcvd |=> st_q.rcv_tgt_abort)
		else $error("received target abort not set");
	a_mst_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_cpl_unsup_rcvd |=> st_q.rcv_mst_abort)
		else $error("received master abort not set");
	// legacy and reserved bits read zero
	a_legacy_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_SEC_STATUS
		|-> s_axi_rdata[26:25] == 2'b00 && s_axi_rdata[23:0] == 24'h00_0000)
		else $error("legacy status bits not zero");
	a_window_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		(txn_addr == {32'h0000_0000, mem_base_x} && st_q.mem_base <= st_q.mem_limit)
		|-> mem_window_hit)
		else $error("memory window base not matched");
	a_pref_code: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && $past(s_axi_araddr) == OFF_PREF_WINDOW && $rose(s_axi_rvalid)
		|-> s_axi_rdata[3:0] == PREF_64BIT_CODE && s_axi_rdata[19:16] == PREF_64BIT_CODE)
		else $error("prefetch capability code wrong");
endmodule : bssw_top

// ### hw/bssw_pkg.sv
package bssw_pkg;
	// byte addresses of the 32-bit words
	localparam logic [7:0] OFF_SEC_STATUS  = 8'h1c;
	localparam logic [7:0] OFF_MEM_WINDOW  = 8'h20;
	localparam logic [7:0] OFF_PREF_WINDOW = 8'h24;
	localparam logic [7:0] OFF_PREF_BASE_HI  = 8'h28;
	localparam logic [7:0] OFF_PREF_LIMIT_HI = 8'h2c;
	localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3c;
	// secondary status bit positions
	localparam int BIT_MASTER_PARITY = 24;
	localparam int BIT_SIG_TGT_ABORT = 27;
	localparam int BIT_RCV_TGT_ABORT = 28;
	localparam int BIT_RCV_MST_ABORT = 29;
	localparam int BIT_RCV_SYS_ERR   = 30;
	localparam int BIT_DET_PARITY    = 31;
	// bridge control bit positions
	localparam int BIT_PARITY_RESP_EN = 16;
	localparam int BIT_SERR_FWD_EN    = 17;
	// window field positions
	localparam int LO_FIELD_LSB = 4;
	localparam int HI_FIELD_LSB = 20;
	localparam int FIELD_W      = 12;
	localparam int ATTR_LSB_LO  = 0;
	localparam int ATTR_LSB_HI  = 16;
	localparam logic [3:0]  PREF_64BIT_CODE = 4'h1;
	localparam logic [11:0] WINDOW_RESET    = 12'h000;
	localparam logic [31:0] UPPER_RESET     = 32'h0000_0000;
	localparam logic [19:0] LOW_ZERO        = 20'h0_0000;
	localparam logic [19:0] LOW_ONES        = 20'hf_ffff;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : bssw_pkg

// ### hw/bssw_window_match.sv
module bssw_window_match
	import bssw_pkg::*;
#(
	parameter int AW = 32
) (
	input  wire logic [AW-1:0] addr,
	input  wire logic [AW-1:0] base,
	input  wire logic [AW-1:0] limit,
	output logic               hit
);
	// inclusive on both ends; empty window when base above limit
	assign hit = (addr >= base) && (addr <= limit);
endmodule : bssw_window_match

// ### test/bssw_top_test.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bridge_secondary_status_and_windows_test
	import bssw_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} bssw_row_t;
	typedef struct packed {
		logic [63:0] a;
		logic        m;
		logic        p;
	} bssw_hit_t;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, mhit, phit, prep, efwd, pen, sen;
	logic [7:0]  awaddr, araddr, ev;
	logic [31:0] wdata, rdata, got;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, br;
	logic [63:0] txn_addr;
	int          n_fail, compares, i;
	// plain read/write/reserved/unmapped cases, window setup last
	bssw_row_t rows[12] = '{
		'{8'h1c, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
		'{8'h20, 32'hffff_ffff, 32'hfff0_fff0, RESP_OKAY},
		'{8'h24, 32'hffff_ffff, 32'hfff1_fff1, RESP_OKAY},
		'{8'h24, 32'h0000_0000, 32'h0001_0001, RESP_OKAY},
		'{8'h28, 32'h1234_5678, 32'h1234_5678, RESP_OKAY},
		'{8'h3c, 32'hffff_ffff, 32'h0003_0000, RESP_OKAY},
		'{8'h3c, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
		'{8'h40, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR},
		'{8'h20, 32'h1ff0_1000, 32'h1ff0_1000, RESP_OKAY},
		'{8'h24, 32'h2ff0_2000, 32'h2ff1_2001, RESP_OKAY},
		'{8'h28, 32'h0000_0001, 32'h0000_0001, RESP_OKAY},
		'{8'h2c, 32'h0000_0001, 32'h0000_0001, RESP_OKAY}};
	// edges of both windows, inclusive on each end
	bssw_hit_t hits[10] = '{
		'{64'h0000_0000_0fff_ffff, 1'b0, 1'b0}, '{64'h0000_0000_1000_0000, 1'b1, 1'b0},
		'{64'h0000_0000_1fff_ffff, 1'b1, 1'b0}, '{64'h0000_0000_2000_0000, 1'b0, 1'b0},
		'{64'h0000_0001_1fff_ffff, 1'b0, 1'b0}, '{64'h0000_0001_2000_0000, 1'b0, 1'b1},
		'{64'h0000_0001_2fff_ffff, 1'b0, 1'b1}, '{64'h0000_0001_3000_0000, 1'b0, 1'b0},
		'{64'h0000_0002_2000_0000, 1'b0, 1'b0}, '{64'h0000_0000_0000_0000, 1'b0, 1'b0}};
	bssw_row_t rst_rows[6] = '{
		'{8'h1c, 32'h0, 32'h0000_0000, RESP_OKAY}, '{8'h20, 32'h0, 32'h0000_0000, RESP_OKAY},
		'{8'h24, 32'h0, 32'h0001_0001, RESP_OKAY}, '{8'h28, 32'h0, 32'h0000_0000, RESP_OKAY},
		'{8'h2c, 32'h0, 32'h0000_0000, RESP_OKAY}, '{8'h3c, 32'h0, 32'h0000_0000, RESP_OKAY}};

	bssw_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ev_sec_parity(ev[0]), .ev_cpl_abort_sent(ev[1]),
		.ev_cpl_abort_rcvd(ev[2]), .ev_cpl_unsup_rcvd(ev[3]), .ev_err_msg_fatal(ev[4]),
		.ev_err_msg_nonfatal(ev[5]), .ev_err_msg_corr(ev[6]), .ev_poisoned_rcvd(ev[7]),
		.txn_addr(txn_addr), .mem_window_hit(mhit), .pref_window_hit(phit),
		.poison_report(prep), .err_msg_forward(efwd), .parity_response_en(pen),
		.system_error_forward_en(sen));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic stop_test;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (k == 50) begin
			n_fail++;
			stop_test();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (k == 50) begin
			n_fail++;
			stop_test();
		end
	endtask : rd

	// one-cycle event burst, then the registered report pulses
	task automatic pulse(input logic [7:0] v, input logic ep, input logic ef);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 8'h00;
		@(posedge aclk);
		`CHK(prep, ep)
		`CHK(efwd, ef)
	endtask : pulse

	task automatic status_is(input logic [31:0] e);
		logic [1:0] r;
		rd(OFF_SEC_STATUS, got, r);
		`CHK(got, e)
	endtask : status_is

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
		{awaddr, araddr, ev, wdata, txn_addr} = '0;
		wstrb = 4'hf;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 12; i++) begin
			wr(rows[i].a, rows[i].d, br);
			`CHK(br, rows[i].r)
			rd(rows[i].a, got, br);
			`CHK(got, rows[i].e)
			`CHK(br, rows[i].r)
		end
		for (i = 0; i < 10; i++) begin
			@(posedge aclk);
			txn_addr <= hits[i].a;
			@(posedge aclk);
			`CHK(mhit, hits[i].m)
			`CHK(phit, hits[i].p)
		end
		// enables off: only detected parity may set
		pulse(8'h91, 1'b0, 1'b0);
		status_is(32'h8000_0000);
		wr(OFF_SEC_STATUS, 32'h8000_0000, br);
		status_is(32'h0000_0000);
		wr(OFF_BRIDGE_CTRL, 32'h0003_0000, br);
		`CHK({pen, sen}, 2'b11)
		pulse(8'h81, 1'b1, 1'b0);
		pulse(8'h4e, 1'b0, 1'b1);
		status_is(32'hb900_0000);
		pulse(8'h10, 1'b0, 1'b1);
		pulse(8'h20, 1'b0, 1'b1);
		status_is(32'hf900_0000);
		// clear by one; abort flags only clear on reset
		wr(OFF_SEC_STATUS, 32'hffff_ffff, br);
		status_is(32'h3800_0000);
		// base bytes only: limit must survive
		wstrb <= 4'h3;
		wr(OFF_MEM_WINDOW, 32'h0000_0000, br);
		wstrb <= 4'hf;
		rd(OFF_MEM_WINDOW, got, br);
		`CHK(got, 32'h1ff0_0000)
		@(posedge aclk);
		aresetn <= 1'b0;
		txn_addr <= 64'h0000_0000_000f_ffff;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK({mhit, phit}, 2'b11)
		for (i = 0; i < 6; i++) begin
			rd(rst_rows[i].a, got, br);
			`CHK(got, rst_rows[i].e)
		end
		`CHK({pen, sen}, 2'b00)
		stop_test();
	end
endmodule : bridge_secondary_status_and_windows_test
